// ### rtl/dpot_pkg.sv
package dpot_pkg;

  // Timing
  localparam int CLOCK_HZ      = 100_000_000;
  localparam int STORE_TIME_MS = 15;
  localparam int STORE_CYCLES  = STORE_TIME_MS * (CLOCK_HZ / 1000);
  localparam int RESET_TIME_US = 30;
  localparam int RESET_CYCLES  = RESET_TIME_US * (CLOCK_HZ / 1_000_000);
  localparam int COUNT_W       = 21;

  // Data values
  localparam logic [7:0] MIDSCALE  = 8'h80;
  localparam logic [7:0] LSB_MASK  = 8'hFE;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Control field codes
  localparam logic [3:0] CMD_NOP           = 4'h0;
  localparam logic [3:0] CMD_WRITE_WIPER   = 4'h1;
  localparam logic [3:0] CMD_WRITE_PRELOAD = 4'h2;
  localparam logic [3:0] CMD_READ          = 4'h3;
  localparam logic [3:0] CMD_COPY          = 4'h7;
  localparam logic [3:0] CMD_WRITE_STORE   = 4'h8;
  localparam logic [3:0] CMD_SOFT_RESET    = 4'hB;
  localparam logic [3:0] CMD_SHUTDOWN      = 4'hC;

  // Channel field and read select codes
  localparam int         BROADCAST_BIT = 3;
  localparam logic [3:0] CH_STORE_2    = 4'h2;
  localparam logic [1:0] READ_STORE    = 2'h1;
  localparam logic [1:0] READ_WIPER    = 2'h3;

  // Three-level address pins
  localparam logic [1:0] PIN_SUPPLY  = 2'h0;
  localparam logic [1:0] PIN_OPEN    = 2'h1;
  localparam logic [1:0] PIN_GROUND  = 2'h2;
  localparam logic [6:0] ADDR_BASE   = 7'h20;
  localparam logic [2:0][6:0] LOW_OFFSET  = {7'h03, 7'h02, 7'h00};
  localparam logic [2:0][6:0] HIGH_OFFSET = {7'h0C, 7'h08, 7'h00};

  typedef struct packed {
    logic [3:0] control_field;
    logic [3:0] channel;
    logic [7:0] data;
  } dpot_word_type;

  typedef struct packed {
    logic [1:0][7:0] setting;
  } dpot_wipers_type;

endpackage

// ### rtl/dpot_sync.sv
`timescale 1ns/1ps
module dpot_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } dpot_sync_type;

  dpot_sync_type sync_reg;
  dpot_sync_type sync_next;

  always_comb begin
    sync_next.first  = async_in;
    sync_next.second = sync_reg.first;
  end

  always_ff @(posedge clock) begin
    sync_reg <= sync_next;
  end

  assign sync_out = sync_reg.second;

endmodule

// ### rtl/dpot_i2c_target.sv
`timescale 1ns/1ps
module dpot_i2c_target (
  input  wire logic                link_clock,
  input  wire logic                link_resetn,
  input  wire logic                scl,
  input  wire logic                sda,
  input  wire logic [1:0]          address_select_pin_low,
  input  wire logic [1:0]          address_select_pin_high,
  input  wire logic                restricted_levels,
  input  wire logic                busy,
  input  wire logic                readback_toggle,
  input  wire logic [7:0]          readback,
  output logic                     sda_out,
  output logic                     sda_oe_n,
  output dpot_pkg::dpot_word_type  word,
  output logic                     word_toggle
);

  typedef enum logic [2:0] {
    LINK_IDLE, LINK_RECV, LINK_ACK, LINK_SEND, LINK_RACK, LINK_IGNORE
  } dpot_link_state_type;

  typedef struct packed {
    dpot_link_state_type      phase;
    logic                     scl_prev;
    logic                     sda_prev;
    logic [7:0]               shift;
    logic [3:0]               bit_count;
    logic                     is_addr;
    logic                     read_mode;
    logic                     have_high;
    logic [7:0]               high_byte;
    dpot_pkg::dpot_word_type  word;
    logic                     word_toggle;
    logic                     readback_seen;
    logic [7:0]               rb_byte;
    logic [7:0]               tx;
    logic                     master_ack;
    logic                     sda_oe_n;
    logic                     sda_level;
  } dpot_link_type;

  dpot_link_type link_reg;
  dpot_link_type link_next;

  // Open level is refused where the supply mode cannot resolve it
  function automatic logic level_ok(input logic [1:0] level, input logic restricted);
    level_ok = (level != 2'h3) && !(restricted && level == dpot_pkg::PIN_OPEN);
  endfunction

  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       addr_ok;
  logic [6:0] own_addr;

  always_comb begin
    rise  = scl && !link_reg.scl_prev;
    fall  = !scl && link_reg.scl_prev;
    start = scl && link_reg.scl_prev && link_reg.sda_prev && !sda;
    stop  = scl && link_reg.scl_prev && !link_reg.sda_prev && sda;
    addr_ok = level_ok(address_select_pin_low, restricted_levels)
           && level_ok(address_select_pin_high, restricted_levels);
    own_addr = dpot_pkg::ADDR_BASE
             + dpot_pkg::LOW_OFFSET[address_select_pin_low[0] ? 1 : (address_select_pin_low[1] ? 2 : 0)]
             + dpot_pkg::HIGH_OFFSET[address_select_pin_high[0] ? 1 : (address_select_pin_high[1] ? 2 : 0)];

    link_next = link_reg;
    link_next.scl_prev = scl;
    link_next.sda_prev = sda;
    if (readback_toggle != link_reg.readback_seen) begin
      link_next.readback_seen = readback_toggle;
      link_next.rb_byte       = readback;
    end
    if (start) begin
      link_next.phase     = LINK_RECV;
      link_next.bit_count = 4'h0;
      link_next.is_addr   = 1'b1;
      link_next.have_high = 1'b0;
      link_next.sda_oe_n  = 1'b1;
    end else if (stop) begin
      link_next.phase    = LINK_IDLE;
      link_next.sda_oe_n = 1'b1;
    end else begin
      unique case (link_reg.phase)
        LINK_IDLE, LINK_IGNORE: begin
        end
        LINK_RECV: begin
          if (rise) begin
            link_next.shift     = {link_reg.shift[6:0], sda};
            link_next.bit_count = link_reg.bit_count + 4'h1;
          end else if (fall && link_reg.bit_count == dpot_pkg::BYTE_BITS) begin
            link_next.phase    = LINK_ACK;
            link_next.sda_oe_n = 1'b0;
            if (link_reg.is_addr) begin
              link_next.read_mode = link_reg.shift[0];
              // Only 7-bit match; reserved and general call never match
              if (link_reg.shift[7:1] != own_addr || !addr_ok || busy) begin
                link_next.phase    = LINK_IGNORE;
                link_next.sda_oe_n = 1'b1;
              end
            end else if (busy) begin
              link_next.phase    = LINK_IGNORE;
              link_next.sda_oe_n = 1'b1;
            end else if (link_reg.have_high) begin
              link_next.word        = {link_reg.high_byte, link_reg.shift};
              link_next.word_toggle = !link_reg.word_toggle;
              link_next.have_high   = 1'b0;
            end else begin
              link_next.high_byte = link_reg.shift;
              link_next.have_high = 1'b1;
            end
          end
        end
        LINK_ACK: begin
          if (fall) begin
            link_next.bit_count = 4'h0;
            link_next.is_addr   = 1'b0;
            if (link_reg.is_addr && link_reg.read_mode) begin
              link_next.tx       = link_reg.rb_byte;
              link_next.sda_oe_n = link_reg.rb_byte[7];
              link_next.phase    = LINK_SEND;
            end else begin
              link_next.sda_oe_n = 1'b1;
              link_next.phase    = LINK_RECV;
            end
          end
        end
        LINK_SEND: begin
          if (rise) begin
            link_next.bit_count = link_reg.bit_count + 4'h1;
          end else if (fall) begin
            if (link_reg.bit_count == dpot_pkg::BYTE_BITS) begin
              link_next.sda_oe_n = 1'b1;
              link_next.phase    = LINK_RACK;
            end else begin
              link_next.tx       = {link_reg.tx[6:0], 1'b0};
              link_next.sda_oe_n = link_reg.tx[6];
            end
          end
        end
        LINK_RACK: begin
          if (rise) begin
            link_next.master_ack = !sda;
          end else if (fall) begin
            link_next.bit_count = 4'h0;
            if (link_reg.master_ack) begin
              link_next.tx       = link_reg.rb_byte;
              link_next.sda_oe_n = link_reg.rb_byte[7];
              link_next.phase    = LINK_SEND;
            end else begin
              link_next.phase = LINK_IGNORE;
            end
          end
        end
      endcase
    end
    link_next.sda_level = 1'b0;
  end

  always_ff @(posedge link_clock) begin
    if (!link_resetn) begin
      link_reg          <= '0;
      link_reg.phase    <= LINK_IDLE;
      link_reg.scl_prev <= 1'b1;
      link_reg.sda_prev <= 1'b1;
      link_reg.sda_oe_n <= 1'b1;
    end else begin
      link_reg <= link_next;
    end
  end

  assign sda_out     = link_reg.sda_level;
  assign sda_oe_n    = link_reg.sda_oe_n;
  assign word        = link_reg.word;
  assign word_toggle = link_reg.word_toggle;

endmodule

// ### rtl/dpot_core.sv
`timescale 1ns/1ps
// Operation
// - Each wiper output follows its wiper setting register; 0x80 is half scale.
// - A preload register per channel stages a setting before use; nothing here loads it into a wiper.
// - After reset, wiper settings are restored from nonvolatile storage.
// - During the 15 ms store, commands are refused and addresses not acknowledged.
// - A command word is 16 bits: control, channel, data fields.
// - Words shift most significant bit first.
// - Half-resolution variant ignores data bit 0 for wiper and storage.
// - Target works at 100 kHz and 400 kHz bus rates.
// - Only 7-bit addressing; no 10-bit or general call response.
// - Matching address is acknowledged on clock nine; direction bit picks read.
// - Nine clocks per byte; data changes only while clock is low.
// - Two three-level pins choose one of nine addresses.
// - Code 0001 writes the data into the chosen wiper setting.
// - Code 0010 writes the data into the chosen preload register.
// - Code 0011 reads storage (01) or wiper setting (11).
// - Code 0111 saves wiper to storage when bit 0 set, else reloads.
// - A separate code writes storage directly.
// - Broadcast bit selects all for shutdown (1100) only; 0000 ch1, 0001 ch2, 0010 ch2 storage.
// - Code 1011 or reset pin low pulse reloads all wipers in 30 us.
// - Any wiper load also overwrites the matching preload register.
module dpot_core #(
  parameter int STORE_CYCLES = dpot_pkg::STORE_CYCLES,
  parameter bit HALF_RES     = 1'b0
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  link_clock,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  input  wire logic [1:0]            address_select_pin_low,
  input  wire logic [1:0]            address_select_pin_high,
  input  wire logic                  restricted_levels,
  input  wire logic                  reset_pin_n,
  output dpot_pkg::dpot_wipers_type  wiper_settings,
  output logic [1:0]                 shutdown,
  output logic                       busy
);

  typedef enum logic [1:0] {
    CORE_RELOAD, CORE_IDLE, CORE_STORE
  } dpot_core_state_type;

  typedef struct packed {
    dpot_core_state_type           mode;
    logic [dpot_pkg::COUNT_W-1:0]  count;
    logic [1:0][7:0]               wiper;
    logic [1:0][7:0]               preload;
    logic [1:0][7:0]               storage;
    logic [1:0]                    shutdown;
    logic [7:0]                    readback;
    logic                          rb_toggle;
    logic                          word_seen;
    logic                          pin_prev;
    logic                          busy;
  } dpot_core_type;

  dpot_core_type core_reg;
  dpot_core_type core_next;

  logic                     link_resetn;
  logic                     scl_sync;
  logic                     sda_sync;
  logic [1:0]               addr_low_sync;
  logic [1:0]               addr_high_sync;
  logic                     restricted_sync;
  logic                     busy_link;
  logic                     rb_toggle_link;
  logic                     word_toggle_link;
  logic                     word_toggle_sys;
  logic                     reset_pin_sync;
  dpot_pkg::dpot_word_type  word;

  // Link-side samplers; the fast link clock oversamples both bus rates
  dpot_sync #(
    .WIDTH (10)
  ) link_sync (
    .clock    (link_clock),
    .async_in ({resetn, scl_in, sda_in, address_select_pin_low, address_select_pin_high,
                restricted_levels, core_reg.busy, core_reg.rb_toggle}),
    .sync_out ({link_resetn, scl_sync, sda_sync, addr_low_sync, addr_high_sync,
                restricted_sync, busy_link, rb_toggle_link})
  );

  dpot_sync #(
    .WIDTH (2)
  ) sys_sync (
    .clock    (clock),
    .async_in ({word_toggle_link, reset_pin_n}),
    .sync_out ({word_toggle_sys, reset_pin_sync})
  );

  dpot_i2c_target target (
    .link_clock              (link_clock),
    .link_resetn             (link_resetn),
    .scl                     (scl_sync),
    .sda                     (sda_sync),
    .address_select_pin_low  (addr_low_sync),
    .address_select_pin_high (addr_high_sync),
    .restricted_levels       (restricted_sync),
    .busy                    (busy_link),
    .readback_toggle         (rb_toggle_link),
    .readback                (core_reg.readback),
    .sda_out                 (sda_out),
    .sda_oe_n                (sda_oe_n),
    .word                    (word),
    .word_toggle             (word_toggle_link)
  );

  // Bit 0 dropped on the half-resolution variant
  function automatic logic [7:0] fit(input logic [7:0] value);
    fit = HALF_RES ? (value & dpot_pkg::LSB_MASK) : value;
  endfunction

  // Channel field names exactly one channel
  function automatic logic single(input logic [3:0] channel);
    single = (channel[3:1] == 3'h0);
  endfunction

  logic       sel;
  logic [7:0] data;

  always_comb begin
    core_next = core_reg;
    sel  = word.channel[0];
    data = word.data;

    unique case (core_reg.mode)
      CORE_IDLE: begin
      end
      CORE_RELOAD, CORE_STORE: begin
        core_next.count = core_reg.count - 1'b1;
        if (core_reg.count <= dpot_pkg::COUNT_W'(1)) begin
          core_next.mode = CORE_IDLE;
          if (core_reg.mode == CORE_RELOAD) begin
            core_next.wiper   = core_reg.storage;
            core_next.preload = core_reg.storage;
          end
        end
      end
    endcase

    if (word_toggle_sys != core_reg.word_seen) begin
      core_next.word_seen = word_toggle_sys;
      if (core_reg.mode == CORE_IDLE) begin
        unique case (word.control_field)
          dpot_pkg::CMD_WRITE_WIPER: begin
            if (single(word.channel)) begin
              core_next.wiper[sel]   = fit(data);
              core_next.preload[sel] = fit(data);
            end
          end
          dpot_pkg::CMD_WRITE_PRELOAD: begin
            if (single(word.channel)) begin
              core_next.preload[sel] = data;
            end
          end
          dpot_pkg::CMD_READ: begin
            if (word.channel[3:2] == 2'h0) begin
              if (data[1:0] == dpot_pkg::READ_STORE && !word.channel[0]) begin
                core_next.readback  = fit(core_reg.storage[word.channel[1]]);
                core_next.rb_toggle = !core_reg.rb_toggle;
              end else if (data[1:0] == dpot_pkg::READ_WIPER && !word.channel[1]) begin
                core_next.readback  = fit(core_reg.wiper[sel]);
                core_next.rb_toggle = !core_reg.rb_toggle;
              end
            end
          end
          dpot_pkg::CMD_COPY: begin
            if (single(word.channel)) begin
              if (data[0]) begin
                core_next.storage[sel] = fit(core_reg.wiper[sel]);
                core_next.mode         = CORE_STORE;
                core_next.count        = dpot_pkg::COUNT_W'(STORE_CYCLES);
              end else begin
                core_next.wiper[sel]   = core_reg.storage[sel];
                core_next.preload[sel] = core_reg.storage[sel];
              end
            end
          end
          dpot_pkg::CMD_WRITE_STORE: begin
            if (word.channel[3:2] == 2'h0 && !word.channel[0]) begin
              core_next.storage[word.channel[1]] = fit(data);
              core_next.mode  = CORE_STORE;
              core_next.count = dpot_pkg::COUNT_W'(STORE_CYCLES);
            end
          end
          dpot_pkg::CMD_SOFT_RESET: begin
            core_next.mode  = CORE_RELOAD;
            core_next.count = dpot_pkg::COUNT_W'(dpot_pkg::RESET_CYCLES);
          end
          dpot_pkg::CMD_SHUTDOWN: begin
            if (word.channel[dpot_pkg::BROADCAST_BIT]) begin
              core_next.shutdown = {2{data[0]}};
            end else if (single(word.channel)) begin
              core_next.shutdown[sel] = data[0];
            end
          end
          default: begin
          end
        endcase
      end
    end

    core_next.pin_prev = reset_pin_sync;
    if (core_reg.pin_prev && !reset_pin_sync) begin
      core_next.mode  = CORE_RELOAD;
      core_next.count = dpot_pkg::COUNT_W'(dpot_pkg::RESET_CYCLES);
    end
    core_next.busy = (core_next.mode != CORE_IDLE);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      core_reg           <= '0;
      core_reg.mode      <= CORE_RELOAD;
      core_reg.count     <= dpot_pkg::COUNT_W'(dpot_pkg::RESET_CYCLES);
      core_reg.wiper     <= {2{dpot_pkg::MIDSCALE}};
      core_reg.preload   <= {2{dpot_pkg::MIDSCALE}};
      core_reg.storage   <= {2{dpot_pkg::MIDSCALE}};
      core_reg.pin_prev  <= 1'b1;
      core_reg.busy      <= 1'b1;
    end else begin
      core_reg <= core_next;
    end
  end

  assign wiper_settings.setting = core_reg.wiper;
  assign shutdown               = core_reg.shutdown;
  assign busy                   = core_reg.busy;

endmodule

// ### bench/dpot_core_chk.sv
`timescale 1ns/1ps
module dpot_core_chk #(
  parameter int STORE_CYCLES = 1500000
) (
  input wire logic                      clock,
  input wire logic                      resetn,
  input wire logic                      scl_in,
  input wire logic                      sda_out,
  input wire logic                      sda_oe_n,
  input wire logic                      reset_pin_n,
  input wire logic                      busy,
  input wire dpot_pkg::dpot_wipers_type wiper_settings
);
  int busy_len_reg;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Length of the current busy period in clocks
  always_ff @(posedge clock) begin
    if (!resetn) begin
      busy_len_reg <= 0;
    end else begin
      busy_len_reg <= busy ? busy_len_reg + 1 : 0;
    end
  end
  property p_busy_powerup;
    $rose(resetn) |-> busy;
  endproperty
  a_busy_powerup: assert property (p_busy_powerup) else $error("no reload after reset");
  property p_wiper_lock;
    $rose(busy) |=> $stable(wiper_settings) [*8];
  endproperty
  a_wiper_lock: assert property (p_wiper_lock) else $error("wiper moved while busy");
  property p_busy_len;
    $fell(busy) |-> (busy_len_reg >= STORE_CYCLES - 2 && busy_len_reg <= STORE_CYCLES + 2)
                 || (busy_len_reg >= 2998 && busy_len_reg <= 3002);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy period length wrong");
  property p_no_ack_busy;
    $fell(sda_oe_n) |-> !busy;
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy) else $error("acknowledge while busy");
  property p_oe_scl_low;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with clock high");
  property p_out_low;
    !sda_oe_n |-> !sda_out;
  endproperty
  a_out_low: assert property (p_out_low) else $error("data line driven high");
  property p_ack_hold;
    $fell(sda_oe_n) |-> !sda_oe_n [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low drive too short");
  property p_reset_pin;
    $fell(reset_pin_n) |-> ##[1:12] busy;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
endmodule

bind dpot_core dpot_core_chk #(.STORE_CYCLES(STORE_CYCLES)) dpot_core_chk_inst (
  .clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .reset_pin_n(reset_pin_n), .busy(busy), .wiper_settings(wiper_settings)
);

// ### bench/dpot_ctrl_model.sv
`timescale 1ns/1ps
// Bus controller; a released line goes high through the pull-up
module dpot_ctrl_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  localparam realtime HALF = 500.0;
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  task automatic start();
    sda_pull = 1'h0;
    #(HALF);
    scl = 1'h1;
    #(HALF);
    sda_pull = 1'h1;
    #(HALF);
    scl = 1'h0;
    #(HALF/2);
  endtask
  task automatic stop();
    sda_pull = 1'h1;
    #(HALF);
    scl = 1'h1;
    #(HALF);
    sda_pull = 1'h0;
    #(HALF);
  endtask
  task automatic bit_io(input logic v, output logic r);
    sda_pull = ~v;
    #(HALF);
    scl = 1'h1;
    #(HALF/2);
    r = sda;
    #(HALF/2);
    scl = 1'h0;
    #(HALF/2);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'h1, r);
    ack = ~r;
  endtask
  task automatic get_byte(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, b[i]);
    bit_io(1'h1, r);
  endtask
endmodule

// ### bench/dpot_core_tb.sv
`timescale 1ns/1ps
module dpot_core_tb;
  localparam int         STORE = 2000;
  localparam logic [6:0] ADDR  = 7'h2B;
  logic                      clock, link_clock, resetn, reset_pin_n, restricted_levels;
  logic                      scl, sda_pull, sda_out, sda_oe_n, busy, a;
  logic [1:0]                pin_lo, pin_hi, shutdown;
  dpot_pkg::dpot_wipers_type wipers;
  int                        n_errors, checked;
  wire                       sda_line = (sda_pull | ~sda_oe_n) ? 1'h0 : 1'h1;
  dpot_core #(.STORE_CYCLES(STORE), .HALF_RES(1'h0)) dpot_core_inst (
    .clock(clock), .resetn(resetn), .link_clock(link_clock), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_pin_low(pin_lo),
    .address_select_pin_high(pin_hi), .restricted_levels(restricted_levels),
    .reset_pin_n(reset_pin_n), .wiper_settings(wipers), .shutdown(shutdown), .busy(busy));
  dpot_ctrl_model dpot_ctrl_model_inst (.scl(scl), .sda_pull(sda_pull), .sda(sda_line));
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  initial begin
    link_clock = 1'h0;
    #1.7;
    forever #3 link_clock = ~link_clock;
  end
  initial begin
    #950_000;
    n_errors++;
    $display("watchdog expired");
    complete_run();
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 8000 && busy !== 1'h0; i++) @(negedge clock);
    check({15'h0, busy}, 16'h0000);
  endtask
  task automatic addr_only(input logic [7:0] ab);
    dpot_ctrl_model_inst.start();
    dpot_ctrl_model_inst.put_byte(ab, a);
    dpot_ctrl_model_inst.stop();
    check({15'h0, a}, 16'h0000);
  endtask
  task automatic cmd(input logic [7:0] hi, input logic [7:0] lo);
    logic b, c, d;
    dpot_ctrl_model_inst.start();
    dpot_ctrl_model_inst.put_byte({ADDR, 1'h0}, b);
    dpot_ctrl_model_inst.put_byte(hi, c);
    dpot_ctrl_model_inst.put_byte(lo, d);
    dpot_ctrl_model_inst.stop();
    repeat (20) @(negedge clock);
    check({13'h0, b, c, d}, 16'h0007);
  endtask
  task automatic rd(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] exp);
    logic [7:0] v;
    cmd(hi, lo);
    dpot_ctrl_model_inst.start();
    dpot_ctrl_model_inst.put_byte({ADDR, 1'h1}, a);
    dpot_ctrl_model_inst.get_byte(v);
    dpot_ctrl_model_inst.stop();
    check({7'h0, a, v}, {8'h01, exp});
  endtask
  task automatic t_powerup();
    @(negedge clock);
    check({15'h0, busy}, 16'h0001);
    wait_idle();
    check(wipers, {dpot_pkg::MIDSCALE, dpot_pkg::MIDSCALE});
    $display("powerup done");
  endtask
  task automatic t_write();
    cmd(8'h10, 8'h40);
    check(wipers, 16'h8040);
    cmd(8'h11, 8'hC3);
    check(wipers, 16'hC340);
    $display("write done");
  endtask
  task automatic t_addr();
    addr_only(8'h40);
    addr_only(8'h00);
    @(negedge clock);
    restricted_levels = 1'h1;
    addr_only({ADDR, 1'h0});
    @(negedge clock);
    restricted_levels = 1'h0;
    $display("address done");
  endtask
  task automatic t_ignore();
    logic [15:0] tbl [4] = '{16'h2055, 16'h50FF, 16'h1499, 16'h0012};
    foreach (tbl[i]) cmd(tbl[i][15:8], tbl[i][7:0]);
    check(wipers, 16'hC340);
    $display("ignore done");
  endtask
  task automatic t_store();
    cmd(8'h70, 8'h01);
    check({15'h0, busy}, 16'h0001);
    addr_only({ADDR, 1'h0});
    wait_idle();
    cmd(8'h10, 8'h11);
    check(wipers, 16'hC311);
    cmd(8'h70, 8'h00);
    check(wipers, 16'hC340);
    wait_idle();
    $display("store done");
  endtask
  task automatic t_read();
    rd(8'h31, 8'h03, 8'hC3);
    rd(8'h32, 8'h01, 8'h80);
    rd(8'h30, 8'h01, 8'h40);
    $display("read done");
  endtask
  task automatic t_shut();
    cmd(8'hC8, 8'h01);
    check({14'h0, shutdown}, 16'h0003);
    cmd(8'hC1, 8'h00);
    check({14'h0, shutdown}, 16'h0001);
    $display("shutdown done");
  endtask
  task automatic t_hwreset();
    cmd(8'h11, 8'h07);
    reset_pin_n = 1'h0;
    repeat (4) @(negedge clock);
    reset_pin_n = 1'h1;
    repeat (20) @(negedge clock);
    check({15'h0, busy}, 16'h0001);
    wait_idle();
    check(wipers, 16'h6640);
    $display("reset pin done");
  endtask
  task automatic t_soft();
    cmd(8'h82, 8'h66);
    check({15'h0, busy}, 16'h0001);
    wait_idle();
    cmd(8'hB0, 8'h00);
    check({15'h0, busy}, 16'h0001);
    wait_idle();
    check(wipers, 16'h6640);
    $display("soft reset done");
  endtask
  initial begin
    n_errors = 0;
    checked = 0;
    resetn = 1'h0;
    reset_pin_n = 1'h1;
    restricted_levels = 1'h0;
    pin_lo = dpot_pkg::PIN_GROUND;
    pin_hi = dpot_pkg::PIN_OPEN;
    repeat (2) @(negedge clock);
    resetn = 1'h1;
    t_powerup();
    t_write();
    t_addr();
    t_ignore();
    t_store();
    t_read();
    t_shut();
    t_soft();
    t_hwreset();
    complete_run();
  end
endmodule
